// ### tlic_pkg.sv
// Purpose: Shared constants of the two-level interrupt controller.
// Assumes: One system clock; sources are indexed by their fixed order.
// Notes: Cycle figures are counts of system clocks.
package tlic_pkg;
  // Vector layout: first source vector and spacing between vectors.
  localparam logic [15:0] VEC_BASE = 16'h0003;
  localparam logic [15:0] VEC_STEP = 16'h0008;
  localparam logic [15:0] RESET_VEC = 16'h0000;
  // Fixed order numbers of the sources handled specially.
  localparam int EXT_ZERO_IDX = 0;
  localparam int EXT_ONE_IDX = 2;
  localparam int PCA_IDX = 10;
  // Bit positions of the external pending flags in the timer control byte.
  localparam int TCR_EXT_ZERO_BIT = 1;
  localparam int TCR_EXT_ONE_BIT = 3;
  // Timing of the response path.
  localparam int CLK_PERIOD_NS = 5;
  localparam int DETECT_CYCLES = 1;
  localparam int LONG_VECTOR_CALL_CYCLES = 4;
  localparam int RETURN_FROM_INTERRUPT_CYCLES = 5;
  localparam int DIV_CYCLES = 8;
  localparam int MIN_RESPONSE = DETECT_CYCLES + LONG_VECTOR_CALL_CYCLES;
  localparam int MAX_RESPONSE = DETECT_CYCLES + RETURN_FROM_INTERRUPT_CYCLES + DIV_CYCLES + LONG_VECTOR_CALL_CYCLES;
  localparam int CNT_W = 3;
  // Values after reset.
  localparam logic RST_PRIO = 1'b0;
  localparam logic RST_ENABLE = 1'b0;
  // Vector call sequencer states.
  typedef enum logic [0:0] {TLIC_IDLE, TLIC_CALL} tlic_call_e;
endpackage

// ### tlic_ctrl.sv
// Purpose: Two-level priority interrupt controller in front of an 8-bit core.
// Assumes: Pending flags and core strobes come from logic on mclk.
// Notes: The vector call is paced here; the core follows vec_req and the call.
`timescale 1ns/10ps

module tlic_ctrl #(
  parameter int NUM_SRC = 18,
  parameter int MATCH_W = 6
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [NUM_SRC-1:0] src_flag,
  input wire logic ext_zero_set,
  input wire logic ext_one_set,
  input wire logic counter_overflow_flag,
  input wire logic [MATCH_W-1:0] module_match_flag,
  input wire logic pwm_overflow_flag,
  input wire logic prio_wr,
  input wire logic [NUM_SRC-1:0] prio_wdata,
  input wire logic en_wr,
  input wire logic [NUM_SRC-1:0] en_wdata,
  input wire logic instr_boundary,
  input wire logic return_from_interrupt,
  output logic [NUM_SRC-1:0] prio_level,
  output logic [NUM_SRC-1:0] enable_reg,
  output logic [7:0] timer_control_reg,
  output logic vec_req,
  output logic vec_high,
  output logic [$clog2(NUM_SRC)-1:0] vec_src,
  output logic [15:0] vec_addr,
  output logic call_busy,
  output logic routine_start,
  output logic active_high,
  output logic active_low
);
  localparam int IDX_W = $clog2(NUM_SRC);

  // The counter array source must exist, and enable bytes cap the count.
  if (NUM_SRC < tlic_pkg::PCA_IDX + 1 || NUM_SRC > 32)
  begin : g_bad_num_src
    $error("NUM_SRC out of range");
  end
  if (MATCH_W < 1 || MATCH_W > 8)
  begin : g_bad_match_w
    $error("MATCH_W out of range");
  end

  logic ext_zero_pending;
  logic ext_one_pending;
  logic next_ext_zero_pending;
  logic next_ext_one_pending;
  logic [NUM_SRC-1:0] next_prio_level;
  logic [NUM_SRC-1:0] next_enable_reg;
  logic [NUM_SRC-1:0] raw;
  logic [NUM_SRC-1:0] live;
  logic [NUM_SRC-1:0] elig_hi;
  logic [NUM_SRC-1:0] elig_lo;
  logic next_vec_req;
  logic next_vec_high;
  logic [IDX_W-1:0] next_vec_src;
  logic [15:0] next_vec_addr;
  logic grant;
  tlic_pkg::tlic_call_e state;
  tlic_pkg::tlic_call_e next_state;
  logic [tlic_pkg::CNT_W-1:0] cnt;
  logic [tlic_pkg::CNT_W-1:0] next_cnt;
  logic next_call_busy;
  logic next_routine_start;
  logic next_active_high;
  logic next_active_low;
  logic hi_any;
  logic next_hi_any;

  // Lowest set index of a mask; low order numbers win the arbitration.
  function automatic logic [IDX_W-1:0] first_set(input logic [NUM_SRC-1:0] m);
    logic [IDX_W-1:0] r;
    r = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--)
    begin
      if (m[i])
      begin
        r = IDX_W'(i);
      end
    end
    return r;
  endfunction

  // Priority and enable bits are written whole by the core's register strobes.
  always_comb
  begin
    next_prio_level = prio_wr ? prio_wdata : prio_level;
    next_enable_reg = en_wr ? en_wdata : enable_reg;
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      prio_level <= {NUM_SRC{tlic_pkg::RST_PRIO}};
      enable_reg <= {NUM_SRC{tlic_pkg::RST_ENABLE}};
    end
    else
    begin
      prio_level <= next_prio_level;
      enable_reg <= next_enable_reg;
    end
  end

  // External flags are latched here; a new edge in the service cycle wins over the clear.
  always_comb
  begin
    next_ext_zero_pending = ext_zero_set ||
      (ext_zero_pending && !(grant && vec_src == IDX_W'(tlic_pkg::EXT_ZERO_IDX)));
    next_ext_one_pending = ext_one_set ||
      (ext_one_pending && !(grant && vec_src == IDX_W'(tlic_pkg::EXT_ONE_IDX)));
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      ext_zero_pending <= 1'b0;
      ext_one_pending <= 1'b0;
      timer_control_reg <= 8'h00;
    end
    else
    begin
      ext_zero_pending <= next_ext_zero_pending;
      ext_one_pending <= next_ext_one_pending;
      timer_control_reg <= 8'h00;
      timer_control_reg[tlic_pkg::TCR_EXT_ZERO_BIT] <= next_ext_zero_pending;
      timer_control_reg[tlic_pkg::TCR_EXT_ONE_BIT] <= next_ext_one_pending;
    end
  end

  // Decode runs every clock; the counter array flags are only read, never cleared here.
  always_comb
  begin
    raw = src_flag;
    raw[tlic_pkg::EXT_ZERO_IDX] = ext_zero_pending;
    raw[tlic_pkg::EXT_ONE_IDX] = ext_one_pending;
    raw[tlic_pkg::PCA_IDX] = counter_overflow_flag || (|module_match_flag) || pwm_overflow_flag;
    live = raw & enable_reg;
    // Levels are gated by their state after this clock, so a return frees its level at once.
    elig_hi = live & prio_level & {NUM_SRC{!next_active_high}};
    elig_lo = live & ~prio_level & {NUM_SRC{!next_active_high && !next_active_low}};
    next_hi_any = |elig_hi;
    next_vec_high = next_hi_any;
    next_vec_src = next_hi_any ? first_set(elig_hi) : first_set(elig_lo);
    next_vec_req = (|(elig_hi | elig_lo)) && !grant && state == tlic_pkg::TLIC_IDLE;
    next_vec_addr = tlic_pkg::VEC_BASE + tlic_pkg::VEC_STEP * 16'(next_vec_src);
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      vec_req <= 1'b0;
      vec_high <= 1'b0;
      vec_src <= '0;
      vec_addr <= tlic_pkg::RESET_VEC;
      hi_any <= 1'b0;
    end
    else
    begin
      vec_req <= next_vec_req;
      vec_high <= next_vec_high;
      vec_src <= next_vec_src;
      vec_addr <= next_vec_addr;
      hi_any <= next_hi_any;
    end
  end

  // A return ends its own instruction, so the call waits for the following boundary.
  assign grant = vec_req && instr_boundary && !return_from_interrupt &&
    state == tlic_pkg::TLIC_IDLE;

  // The grant clock is the first call clock; three more follow before the routine starts.
  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_routine_start = 1'b0;
    next_active_high = active_high;
    next_active_low = active_low;
    unique case (state)
      tlic_pkg::TLIC_IDLE:
      begin
        if (grant)
        begin
          next_state = tlic_pkg::TLIC_CALL;
          next_cnt = tlic_pkg::CNT_W'(tlic_pkg::LONG_VECTOR_CALL_CYCLES - 1);
          if (vec_high)
          begin
            next_active_high = 1'b1;
          end
          else
          begin
            next_active_low = 1'b1;
          end
        end
      end
      tlic_pkg::TLIC_CALL:
      begin
        if (cnt == tlic_pkg::CNT_W'(1))
        begin
          next_state = tlic_pkg::TLIC_IDLE;
          next_routine_start = 1'b1;
        end
        else
        begin
          next_cnt = cnt - tlic_pkg::CNT_W'(1);
        end
      end
    endcase
    // A return closes the innermost routine, which is the high one when both run.
    if (return_from_interrupt && !grant)
    begin
      if (active_high)
      begin
        next_active_high = 1'b0;
      end
      else
      begin
        next_active_low = 1'b0;
      end
    end
    next_call_busy = next_state == tlic_pkg::TLIC_CALL;
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      state <= tlic_pkg::TLIC_IDLE;
      cnt <= '0;
      call_busy <= 1'b0;
      routine_start <= 1'b0;
      active_high <= 1'b0;
      active_low <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      call_busy <= next_call_busy;
      routine_start <= next_routine_start;
      active_high <= next_active_high;
      active_low <= next_active_low;
    end
  end

  // Checks on the controller's own outputs and internal state.
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);

  AST_PRIO_RESET: assert property ($past(srst) && !prio_wr |-> prio_level == '0)
    else $error("priority bits not low after reset");
  AST_NO_PREEMPT_HIGH: assert property (active_high |-> !grant)
    else $error("high routine pre-empted");
  AST_HIGH_FIRST: assert property (vec_req && hi_any |-> vec_high && prio_level[vec_src])
    else $error("low request chosen over high");
  AST_DECODE_EACH_CLOCK: assert property (state == tlic_pkg::TLIC_IDLE && !grant &&
    (|(elig_hi | elig_lo)) |=> vec_req)
    else $error("eligible request not decoded next clock");
  AST_MIN_LATENCY: assert property (grant |-> ##4 routine_start)
    else $error("routine start not four clocks after grant");
  AST_NO_CALL_ON_RETURN: assert property (return_from_interrupt |-> !grant)
    else $error("vector call on the return boundary");
  AST_CALL_LENGTH: assert property (grant |=> call_busy [*3] ##1 (!call_busy && routine_start))
    else $error("vector call length wrong");
  AST_HOLD_EQUAL: assert property (grant && active_low |-> vec_high)
    else $error("equal level request served inside routine");
  AST_EXT_ZERO_CLEAR: assert property (grant && vec_src == IDX_W'(tlic_pkg::EXT_ZERO_IDX) && !ext_zero_set
    |=> !ext_zero_pending)
    else $error("external zero flag not cleared on service");
  AST_EXT_ONE_CLEAR: assert property (grant && vec_src == IDX_W'(tlic_pkg::EXT_ONE_IDX) && !ext_one_set
    |=> !ext_one_pending)
    else $error("external one flag not cleared on service");
  AST_PCA_VECTOR: assert property (vec_req && vec_src == IDX_W'(tlic_pkg::PCA_IDX) |-> vec_addr == 16'h0053)
    else $error("counter array vector wrong");
  AST_VEC_SPACING: assert property (vec_req |-> vec_addr == tlic_pkg::VEC_BASE + 16'(vec_src) * 16'h0008)
    else $error("vector address not on eight byte grid");

  COV_PREEMPT: cover property (active_low && grant && vec_high);
  COV_RETURN_THEN_CALL: cover property (return_from_interrupt ##1 grant);
  COV_EXT_ZERO: cover property (grant && vec_src == IDX_W'(tlic_pkg::EXT_ZERO_IDX));
  COV_PCA: cover property (grant && vec_src == IDX_W'(tlic_pkg::PCA_IDX));
endmodule // tlic_ctrl

// ### tlic_core_model.sv
// Purpose: Core model that paces instruction ends for the controller.
// Assumes: One instruction ends every ilen clocks outside a vector call.
// Notes: A return ends an instruction only if it finishes while ret_cmd is high; ret_cmd is not stored.
`timescale 1ns/10ps
module tlic_core_model (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [3:0] ilen,
  input wire logic ret_cmd,
  input wire logic call_busy,
  output logic instr_boundary,
  output logic return_from_interrupt
);
  logic [3:0] cnt;
  // The stall acts through a register, so no instruction ends in the clock after each call_busy clock.
  always @(posedge mclk)
  begin
    if (srst || call_busy || cnt != 4'h0)
    begin
      instr_boundary <= 1'b0;
      cnt <= (srst || call_busy) ? ilen - 4'h1 : cnt - 4'h1;
    end
    else
    begin
      instr_boundary <= 1'b1;
      cnt <= ilen - 4'h1;
    end
  end
  // A return is only ever flagged together with an instruction end.
  assign return_from_interrupt = instr_boundary & ret_cmd;
endmodule // tlic_core_model

// ### testbench.sv
// Purpose: Self-checking bench for the two-level interrupt controller.
// Assumes: The core model ends one instruction per clock outside a vector call.
// Notes: Stimulus changes on the falling edge only.
`timescale 1ns/10ps
module testbench;
  logic mclk, srst, ext_zero_set, ext_one_set, cof, pwm, prio_wr, en_wr, ret_cmd;
  logic instr_boundary, return_from_interrupt, vec_req, vec_high, call_busy, routine_start, active_high, active_low;
  logic [17:0] src_flag, prio_wdata, en_wdata, prio_level, enable_reg;
  logic [5:0] mmf, s;
  logic [7:0] timer_control_reg, tc;
  logic [4:0] vec_src;
  logic [15:0] vec_addr, a;
  int mismatches = 0, checks_done = 0, n;
  tlic_ctrl uut (.mclk(mclk), .srst(srst), .src_flag(src_flag), .ext_zero_set(ext_zero_set),
    .ext_one_set(ext_one_set), .counter_overflow_flag(cof), .module_match_flag(mmf),
    .pwm_overflow_flag(pwm), .prio_wr(prio_wr), .prio_wdata(prio_wdata), .en_wr(en_wr),
    .en_wdata(en_wdata), .instr_boundary(instr_boundary), .return_from_interrupt(return_from_interrupt),
    .prio_level(prio_level), .enable_reg(enable_reg), .timer_control_reg(timer_control_reg),
    .vec_req(vec_req), .vec_high(vec_high), .vec_src(vec_src), .vec_addr(vec_addr),
    .call_busy(call_busy), .routine_start(routine_start), .active_high(active_high), .active_low(active_low));
  tlic_core_model core (.mclk(mclk), .srst(srst), .ilen(4'h1), .ret_cmd(ret_cmd), .call_busy(call_busy),
    .instr_boundary(instr_boundary), .return_from_interrupt(return_from_interrupt));
  // Free-running clock at 200 MHz.
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task print_verdict;
    $display("Checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task chk(input string nm, input logic [17:0] e, input logic [17:0] g);
    checks_done++;
    if (g !== e)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [17:0] va(input int idx);
    return 18'h00003 + 18'h00008 * 18'(idx);
  endfunction
  task cfg(input logic [17:0] en, input logic [17:0] pr);
    @(negedge mclk);
    {en_wr, en_wdata, prio_wr, prio_wdata} = {1'b1, en, 1'b1, pr};
    @(negedge mclk);
    {en_wr, prio_wr} = 2'b00;
  endtask
  // Drives one request at a falling edge and counts edges to the first routine clock.
  // Sampling starts at the very next falling edge, since a granted request stands only one clock.
  task serve(input logic [17:0] f, input logic r, input logic [1:0] e, input logic [7:0] p);
    @(negedge mclk);
    src_flag = src_flag | f;
    ret_cmd = r;
    {ext_one_set, ext_zero_set} = e;
    {pwm, mmf, cof} = p;
    n = 0;
    a = 16'h0000;
    s = 6'h00;
    tc = 8'h00;
    do
    begin
      @(negedge mclk);
      ret_cmd = 1'b0;
      {ext_one_set, ext_zero_set} = 2'b00;
      n++;
      tc = tc | timer_control_reg;
      if (vec_req === 1'b1)
      begin
        a = vec_addr;
        s = {vec_high, vec_src};
      end
    end
    while (routine_start !== 1'b1 && n < 40);
  endtask
  task ret;
    @(negedge mclk);
    ret_cmd = 1'b1;
    @(negedge mclk);
    ret_cmd = 1'b0;
  endtask
  task t_reset;
    chk("prio", 18'h00000, prio_level);
    chk("addr", 18'h00000, {2'b00, vec_addr});
  endtask
  task t_latency;
    cfg(18'h00020, 18'h00000);
    chk("en", 18'h00020, enable_reg);
    serve(18'h00020, 1'b0, 2'b00, 8'h00);
    chk("edges", 18'h00005, n[17:0]);
    chk("addr", va(5), {2'b00, a});
    src_flag = 18'h00000;
    ret;
  endtask
  task t_order;
    cfg(18'h00090, 18'h00000);
    serve(18'h00090, 1'b0, 2'b00, 8'h00);
    chk("addr", va(4), {2'b00, a});
    chk("src", 18'h00004, {12'h000, s});
    src_flag = 18'h00000;
    ret;
    cfg(18'h00090, 18'h00080);
    chk("prio", 18'h00080, prio_level);
    serve(18'h00090, 1'b0, 2'b00, 8'h00);
    chk("addr", va(7), {2'b00, a});
    chk("src", 18'h00027, {12'h000, s});
    src_flag = 18'h00000;
    ret;
  endtask
  // A low routine is overtaken by a high one, which then holds off another high one.
  task t_preempt;
    cfg(18'h000D0, 18'h000C0);
    serve(18'h00010, 1'b0, 2'b00, 8'h00);
    src_flag = 18'h00000;
    serve(18'h00080, 1'b0, 2'b00, 8'h00);
    chk("addr", va(7), {2'b00, a});
    chk("act", 18'h00003, {16'h0000, active_high, active_low});
    src_flag = 18'h00040;
    repeat (6) @(negedge mclk);
    chk("req", 18'h00000, {17'h00000, vec_req});
    chk("busy", 18'h00000, {17'h00000, call_busy});
    // The return clock, then the four clock call, whose first clock is the next instruction end.
    serve(18'h00000, 1'b1, 2'b00, 8'h00);
    chk("edges", 18'h00005, n[17:0]);
    chk("addr", va(6), {2'b00, a});
    src_flag = 18'h00000;
    ret;
    ret;
    chk("act", 18'h00000, {16'h0000, active_high, active_low});
  endtask
  task t_ext;
    for (int k = 0; k < 2; k++)
    begin
      cfg(k ? 18'h00004 : 18'h00001, 18'h00000);
      serve(18'h00000, 1'b0, k ? 2'b10 : 2'b01, 8'h00);
      chk("tcr", k ? 18'h00008 : 18'h00002, {10'h000, tc});
      chk("addr", k ? 18'h00013 : 18'h00003, {2'b00, a});
      chk("tcr", 18'h00000, {10'h000, timer_control_reg});
      ret;
    end
  endtask
  task t_counter;
    cfg(18'h00400, 18'h00000);
    for (int j = 0; j < 3; j++)
    begin
      serve(18'h00000, 1'b0, 2'b00, {j == 2, 5'h00, j == 1, j == 0});
      chk("addr", 18'h00053, {2'b00, a});
      {pwm, mmf, cof} = 8'h00;
      ret;
    end
  endtask
  // Cuts a hung run short.
  initial
  begin
    #20000;
    mismatches++;
    print_verdict;
  end
  initial
  begin
    {srst, ext_zero_set, ext_one_set, cof, pwm, prio_wr, en_wr, ret_cmd} = 8'h80;
    {src_flag, prio_wdata, en_wdata, mmf} = 60'h0;
    repeat (12) @(negedge mclk);
    // Reset values are looked at while reset still holds; decode runs from the first free edge.
    t_reset;
    srst = 1'b0;
    @(negedge mclk);
    t_latency;
    t_order;
    t_preempt;
    t_ext;
    t_counter;
    print_verdict;
  end
endmodule // testbench
